// ### include/sram_ctl_pkg.sv
// Constants and types for the static memory controller
package sram_ctl_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 100;
    // Slower grade figures bound both grades
    localparam int T_READ_CYCLE_NS = 12;
    localparam int T_ACCESS_NS = 12;
    localparam int T_RELEASE_NS = 6;
    // Least times round up, at least one cycle
    localparam int RD_CYC = (T_READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int REL_CYC = (T_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] ACC_CNT = 3'(ACC_CYC);
    localparam logic [2:0] REL_CNT = 3'(REL_CYC);
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    typedef enum logic [2:0] {ST_IDLE, ST_RD_SETUP, ST_RD_WAIT, ST_WR_SETUP, ST_WR_STROBE,
        ST_WR_END, ST_RELEASE} ctl_state_t;
endpackage

// ### include/sram_pin_if.sv
// Pin bundle between the sequencer and the pin stage
`timescale 1ns/1ps
`default_nettype none
interface sram_pin_if;
    import sram_ctl_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic [DATA_W-1:0] wdata;
    logic drive;
    logic [DATA_W-1:0] rdata;
    modport seq (output addr, sel_n, oe_n, we_n, wdata, drive, input rdata);
    modport pins (input addr, sel_n, oe_n, we_n, wdata, drive, output rdata);
endinterface
`default_nettype wire

// ### rtl/sram_pin_stage.sv
// Pin stage: synchronises returning data
`timescale 1ns/1ps
`default_nettype none
module sram_pin_stage
    import sram_ctl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sequencer side
    sram_pin_if.pins p,
    // Raw data pins
    input wire logic [DATA_W-1:0] pin_in
);
    typedef struct packed {
        logic [DATA_W-1:0] meta;
        logic [DATA_W-1:0] sync;
    } sync_t;
    sync_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.meta = pin_in;
        s_d.sync = s_q.meta;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign p.rdata = s_q.sync;
endmodule
`default_nettype wire

// ### rtl/sram_ctl.sv
// Host controller for an asynchronous 512K x 8 static memory
`timescale 1ns/1ps
`default_nettype none
module sram_ctl
    import sram_ctl_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // User request
    input wire logic REQ,
    input wire logic WRITE,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    output logic READY,
    output logic RVALID,
    output logic [DATA_W-1:0] RDATA,
    // Memory pins
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic MEM_SEL_N,
    output logic MEM_OE_N,
    output logic MEM_WE_N,
    input wire logic [DATA_W-1:0] MEM_DATA_I,
    output logic [DATA_W-1:0] MEM_DATA_O,
    output logic MEM_DATA_OE
);
    typedef struct packed {
        ctl_state_t st;
        logic [2:0] cnt;
        logic [ADDR_W-1:0] addr;
        logic sel_n;
        logic oe_n;
        logic we_n;
        logic drive;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } ctl_t;
    ctl_t r_q, r_d;
    sram_pin_if pif();
    sram_pin_stage u_pins (
        .clk(MCLK),
        .rst(RST),
        .p(pif.pins),
        .pin_in(MEM_DATA_I)
    );
    assign pif.addr = r_q.addr;
    assign pif.sel_n = r_q.sel_n;
    assign pif.oe_n = r_q.oe_n;
    assign pif.we_n = r_q.we_n;
    assign pif.wdata = r_q.wdata;
    assign pif.drive = r_q.drive;

    always_comb begin
        r_d = r_q;
        r_d.rvalid = 1'b0;
        case (r_q.st)
            ST_IDLE: begin
                // Deselected, port released; no refresh ever needed
                r_d.sel_n = 1'b1;
                r_d.oe_n = 1'b1;
                r_d.we_n = 1'b1;
                r_d.drive = 1'b0;
                if (REQ) begin
                    // Address set up before select falls
                    r_d.addr = ADDR;
                    r_d.wdata = WDATA;
                    r_d.st = WRITE ? ST_WR_SETUP : ST_RD_SETUP;
                end
            end
            ST_RD_SETUP: begin
                // Address fixed while selected, so data follows it alone
                // Write strobe high, port not driven before output enable
                r_d.sel_n = 1'b0;
                r_d.oe_n = 1'b0;
                r_d.we_n = 1'b1;
                r_d.drive = 1'b0;
                r_d.cnt = ACC_CNT;
                r_d.st = ST_RD_WAIT;
            end
            ST_RD_WAIT: begin
                // Wait out access plus two-stage sampling
                if (r_q.cnt == 3'h0) begin
                    r_d.rdata = pif.rdata;
                    r_d.rvalid = 1'b1;
                    r_d.sel_n = 1'b1;
                    r_d.oe_n = 1'b1;
                    r_d.cnt = REL_CNT;
                    r_d.st = ST_RELEASE;
                end else begin
                    r_d.cnt = r_q.cnt - 3'h1;
                end
            end
            ST_WR_SETUP: begin
                // Output enable high and data driven before strobe
                r_d.sel_n = 1'b0;
                r_d.oe_n = 1'b1;
                r_d.drive = 1'b1;
                r_d.st = ST_WR_STROBE;
            end
            ST_WR_STROBE: begin
                // Write window is select and strobe both low
                r_d.we_n = 1'b0;
                r_d.st = ST_WR_END;
            end
            ST_WR_END: begin
                // Strobe rises first; data held through that edge
                r_d.we_n = 1'b1;
                r_d.cnt = REL_CNT;
                r_d.st = ST_RELEASE;
            end
            ST_RELEASE: begin
                // Float time before the next cycle
                r_d.sel_n = 1'b1;
                r_d.drive = 1'b0;
                if (r_q.cnt == 3'h0) begin
                    r_d.st = ST_IDLE;
                end else begin
                    r_d.cnt = r_q.cnt - 3'h1;
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            r_q.st <= ST_IDLE;
            r_q.cnt <= 3'h0;
            r_q.addr <= ADDR_RST;
            r_q.sel_n <= 1'b1;
            r_q.oe_n <= 1'b1;
            r_q.we_n <= 1'b1;
            r_q.drive <= 1'b0;
            r_q.wdata <= DATA_RST;
            r_q.rdata <= DATA_RST;
            r_q.rvalid <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign READY = (r_q.st == ST_IDLE);
    assign RVALID = r_q.rvalid;
    assign RDATA = r_q.rdata;
    assign MEM_ADDR = pif.addr;
    assign MEM_SEL_N = pif.sel_n;
    assign MEM_OE_N = pif.oe_n;
    assign MEM_WE_N = pif.we_n;
    assign MEM_DATA_O = pif.wdata;
    assign MEM_DATA_OE = pif.drive;

    AST_NO_CONTENTION: assert property (@(posedge MCLK) disable iff (RST)
        !(MEM_DATA_OE && !MEM_OE_N && !MEM_SEL_N))
        else $error("controller drives port while memory output enabled");
    AST_WE_HIGH_IN_READ: assert property (@(posedge MCLK) disable iff (RST)
        !MEM_OE_N |-> MEM_WE_N)
        else $error("write strobe low during read");
    AST_ADDR_STABLE: assert property (@(posedge MCLK) disable iff (RST)
        (!MEM_SEL_N && !$past(MEM_SEL_N)) |-> $stable(MEM_ADDR))
        else $error("address changed while selected");
    AST_READ_LEN: assert property (@(posedge MCLK) disable iff (RST)
        $fell(MEM_OE_N) |-> !MEM_OE_N [*3])
        else $error("read cycle too short");
    AST_READ_DONE: assert property (@(posedge MCLK) disable iff (RST)
        $fell(MEM_SEL_N) && MEM_WE_N && !MEM_DATA_OE |-> ##3 RVALID)
        else $error("read result not on time");
    AST_WR_DATA_HELD: assert property (@(posedge MCLK) disable iff (RST)
        $rose(MEM_WE_N) |-> MEM_DATA_OE && !MEM_SEL_N)
        else $error("write ended without data or select");
    AST_WR_OE_HIGH: assert property (@(posedge MCLK) disable iff (RST)
        !MEM_WE_N |-> MEM_OE_N && MEM_DATA_OE && !MEM_SEL_N)
        else $error("bad write pin state");
    AST_RELEASE_GAP: assert property (@(posedge MCLK) disable iff (RST)
        $rose(MEM_SEL_N) |-> MEM_SEL_N [*2])
        else $error("deselect gap too short");

    // Idle and deselect pin states
    AST_IDLE_DESELECT: assert property (@(posedge MCLK) disable iff (RST)
        READY |-> MEM_SEL_N && MEM_WE_N && !MEM_DATA_OE)
        else $error("pins active while idle");
    AST_DESELECT_QUIET: assert property (@(posedge MCLK) disable iff (RST)
        MEM_SEL_N |-> MEM_WE_N && MEM_OE_N)
        else $error("strobe or output enable low while deselected");
    AST_OE_SELECTED: assert property (@(posedge MCLK) disable iff (RST)
        !MEM_OE_N |-> !MEM_SEL_N)
        else $error("output enable low without select");
    AST_DRIVE_OE_HIGH: assert property (@(posedge MCLK) disable iff (RST)
        MEM_DATA_OE |-> MEM_OE_N)
        else $error("port driven with memory output enabled");
    AST_DRIVE_OFF_FIRST: assert property (@(posedge MCLK) disable iff (RST)
        $fell(MEM_OE_N) |-> !$past(MEM_DATA_OE))
        else $error("port still driven when output enable fell");
    AST_DRIVE_SELECTED: assert property (@(posedge MCLK) disable iff (RST)
        $rose(MEM_DATA_OE) |-> !MEM_SEL_N)
        else $error("port driven without select");
    AST_DESELECT_RELEASE: assert property (@(posedge MCLK) disable iff (RST)
        $rose(MEM_SEL_N) |-> !MEM_DATA_OE)
        else $error("port still driven after deselect");

    // Read result
    AST_RVALID_PULSE: assert property (@(posedge MCLK) disable iff (RST)
        RVALID |=> !RVALID)
        else $error("read valid longer than one cycle");
    AST_RVALID_AFTER_OE: assert property (@(posedge MCLK) disable iff (RST)
        RVALID |-> !$past(MEM_OE_N))
        else $error("read result without output enable");
    AST_RVALID_CLOSED: assert property (@(posedge MCLK) disable iff (RST)
        RVALID |-> MEM_SEL_N && MEM_OE_N)
        else $error("memory still enabled at read result");
    AST_RVALID_GAP: assert property (@(posedge MCLK) disable iff (RST)
        RVALID |=> !READY)
        else $error("ready before release time");
    AST_CNT_BOUND: assert property (@(posedge MCLK) disable iff (RST)
        r_q.cnt <= ACC_CNT)
        else $error("wait counter out of range");

    // Write window
    AST_WE_PULSE: assert property (@(posedge MCLK) disable iff (RST)
        $fell(MEM_WE_N) |=> MEM_WE_N)
        else $error("write strobe not one cycle");
    AST_WE_AFTER_SEL: assert property (@(posedge MCLK) disable iff (RST)
        $fell(MEM_WE_N) |-> !$past(MEM_SEL_N))
        else $error("strobe fell before select");
    AST_WR_ADDR_SET: assert property (@(posedge MCLK) disable iff (RST)
        $fell(MEM_WE_N) |-> $stable(MEM_ADDR) && $stable(MEM_DATA_O))
        else $error("address or data moved at strobe");
    AST_WDATA_STABLE: assert property (@(posedge MCLK) disable iff (RST)
        (!MEM_SEL_N && !$past(MEM_SEL_N)) |-> $stable(MEM_DATA_O))
        else $error("write data changed while selected");
    AST_WR_DONE: assert property (@(posedge MCLK) disable iff (RST)
        $fell(MEM_WE_N) |-> ##2 (MEM_SEL_N && !MEM_DATA_OE))
        else $error("write not closed on time");
endmodule
`default_nettype wire

// ### sim/sram_model.sv
// Behavioural 512K x 8 static memory for the bench
`timescale 1ns/1ps
`default_nettype none
module sram_model
    import sram_ctl_pkg::*;
#(parameter int DLY = 12)
(
    // Memory pins
    input wire logic [ADDR_W-1:0] addr,
    input wire logic sel_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [DATA_W-1:0] din,
    input wire logic din_oe,
    output logic [DATA_W-1:0] dout,
    output logic clash
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rd;
    logic on, on_d, wr;
    assign on = !sel_n && we_n && !oe_n;
    assign #(DLY) rd = mem[addr];
    assign #(DLY/4) on_d = on;
    assign wr = !sel_n && !we_n;
    assign clash = on_d && din_oe;
    // Floating port shows the inverse byte
    always_comb begin
        if (din_oe) begin
            dout = din;
        end else if (on_d) begin
            dout = rd;
        end else begin
            dout = ~rd;
        end
    end
    always @(negedge wr) begin
        mem[addr] = din_oe ? din : 'x;
    end
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sram_ctl_pkg::*;
    logic MCLK, RST, REQ, WRITE, READY, RVALID, MEM_SEL_N, MEM_OE_N, MEM_WE_N, MEM_DATA_OE, clash;
    logic [ADDR_W-1:0] ADDR, MEM_ADDR, pick, cur_a;
    logic [DATA_W-1:0] WDATA, RDATA, MEM_DATA_I, MEM_DATA_O;
    logic [DATA_W-1:0] ref_mem [int];
    logic [ADDR_W-1:0] pool [8];
    int err_total, n_checks, seed, i;
    sram_ctl sram_ctl_i (.MCLK(MCLK), .RST(RST), .REQ(REQ), .WRITE(WRITE), .ADDR(ADDR), .WDATA(WDATA),
        .READY(READY), .RVALID(RVALID), .RDATA(RDATA), .MEM_ADDR(MEM_ADDR), .MEM_SEL_N(MEM_SEL_N),
        .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N), .MEM_DATA_I(MEM_DATA_I), .MEM_DATA_O(MEM_DATA_O),
        .MEM_DATA_OE(MEM_DATA_OE));
    sram_model sram_model_i (.addr(MEM_ADDR), .sel_n(MEM_SEL_N), .oe_n(MEM_OE_N), .we_n(MEM_WE_N),
        .din(MEM_DATA_O), .din_oe(MEM_DATA_OE), .dout(MEM_DATA_I), .clash(clash));
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic step(inout int n);
        @(posedge MCLK);
        #1;
        n++;
        if (n > 20) begin
            err_total++;
            wrap_up();
        end
    endtask
    task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (READY !== 1'b1) step(n);
        @(posedge MCLK);
        REQ <= 1'b1;
        WRITE <= w;
        ADDR <= a;
        WDATA <= d;
        cur_a = a;
        @(posedge MCLK);
        REQ <= 1'b0;
        #1;
        if (w) begin
            ref_mem[a] = d;
        end else begin
            while (RVALID !== 1'b1) step(n);
            chk(RDATA, ref_mem[a]);
            @(posedge MCLK);
            #1;
            chk(RVALID, 1'b0);
        end
    endtask
    // Pin watch on every falling clock edge outside reset; address checked while selected
    always @(negedge MCLK) begin
        if (!RST) begin
            chk(clash, 1'b0);
            if (MEM_DATA_OE === 1'b1) chk(RVALID, 1'b0);
            if (MEM_OE_N === 1'b0) chk(MEM_WE_N, 1'b1);
            if (MEM_SEL_N === 1'b0) chk(MEM_ADDR, cur_a);
        end
    end
    initial begin
        seed = 57300;
        err_total = 0;
        n_checks = 0;
        RST = 1'b1;
        REQ = 1'b0;
        WRITE = 1'b0;
        ADDR = '0;
        WDATA = '0;
        cur_a = '0;
        repeat (5) @(posedge MCLK);
        RST <= 1'b0;
        pool[0] = 19'h00000;
        pool[1] = 19'h7FFFF;
        for (i = 2; i < 8; i++) pool[i] = 19'($random(seed));
        for (i = 0; i < 8; i++) op(1'b1, pool[i], 8'($random(seed)));
        for (i = 0; i < 60; i++) begin
            pick = pool[$unsigned($random(seed)) % 8];
            op(1'($random(seed)), pick, 8'($random(seed)));
        end
        // Let a pending write finish before reset
        i = 0;
        while (READY !== 1'b1) step(i);
        @(posedge MCLK);
        RST <= 1'b1;
        @(posedge MCLK);
        #1;
        chk({MEM_SEL_N, MEM_OE_N, MEM_WE_N, MEM_DATA_OE, READY}, 5'h1D);
        chk({RVALID, RDATA}, {1'b0, DATA_RST});
        @(posedge MCLK);
        RST <= 1'b0;
        for (i = 0; i < 8; i++) op(1'b0, pool[i], 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
